//--- logic/rsa_cfg.svh
// Constants for the radix subtract and shift datapath
`ifndef RSA_CFG_SVH
`define RSA_CFG_SVH
`define RSA_OPC_IMM_SUB_X  13'h1890
`define RSA_OPC_IMM_SUB_Y  13'h18B0
`define RSA_OPC_RADIX_REG  13'h10C0
`define RSA_OPC_RADIX_BASE 13'h1C00
`define RSA_OPC_SET_BASE   13'h1600
`define RSA_OPC_LSHIFT_A   13'h10F0
`define RSA_OPC_LSHIFT_B   13'h10F4
`define RSA_EXT_PAGE_X     8'h00
`define RSA_EXT_PAGE_Y     8'hFF
`define RSA_SHORT_PAGE_LO  10'h000
`define RSA_SHORT_PAGE_HI  10'h3FF
`define RSA_RST_NIB        4'h0
`define RSA_RST_PTR        16'h0000
`endif

//--- logic/rsa_pkg.sv
// Types shared by the radix subtract and shift datapath
package rsa_pkg;
  typedef enum logic [2:0] {
    RSA_OP_NONE, RSA_OP_IMM_SUB, RSA_OP_RADIX_REG, RSA_OP_RADIX_MSRC,
    RSA_OP_RADIX_MDST, RSA_OP_RADIX_CARRY, RSA_OP_SET, RSA_OP_LSHIFT
  } rsa_op_type;
  typedef enum logic [1:0] {RSA_ST_IDLE, RSA_ST_READ, RSA_ST_WRITE} rsa_state_type;
endpackage : rsa_pkg

//--- logic/rsa_mem_if.sv
// Operand and result carrier between the sequencer and the radix arithmetic unit
`timescale 1ns/1ps
interface rsa_mem_if;
  logic [3:0] lhs;
  logic [3:0] rhs;
  logic       cin;
  logic [4:0] radix;
  logic       adjust;
  logic [3:0] res;
  logic       bout;
  modport master (output lhs, output rhs, output cin, output radix, output adjust,
                  input res, input bout);
  modport unit   (input lhs, input rhs, input cin, input radix, input adjust,
                  output res, output bout);
endinterface : rsa_mem_if

//--- logic/rsa_radix_sub.sv
// Subtract with borrow, optionally folded into a radix from 1 to 16
`timescale 1ns/1ps
module rsa_radix_sub (
  rsa_mem_if.unit au
);
  logic [5:0] raw;
  logic       under;
  logic [5:0] wrapped;
  // Binary difference; sign bit of the 6-bit result marks a borrow
  assign raw     = {2'h0, au.lhs} - {2'h0, au.rhs} - {5'h00, au.cin};
  assign under   = raw[5];
  // Borrow in a radix folds back by adding the radix, not by 16
  assign wrapped = raw + {1'b0, au.radix};
  assign au.res  = au.adjust ? (under ? wrapped[3:0] : raw[3:0]) : raw[3:0];
  assign au.bout = under;
endmodule : rsa_radix_sub

//--- logic/rsa_core.sv
// Execution datapath for radix subtract, bit set and logical left shift
//
// How it works
// - Immediate subtract post-inc: mem minus nibble minus carry, pointer bumps, two cycles
// - Register radix subtract: B minus A minus carry, radix-adjusted, radix carry
// - Radix field zero means sixteen; other values are the radix itself
// - Memory-source radix subtract: B minus memory minus carry into B, two cycles
// - Extension gives 0000H+ext for first pointer, FF00H+ext for second
// - Post-inc memory-source radix: result to B, flags from B, pointer bumps
// - Memory-destination radix: memory minus B minus carry written back
// - Carry-only radix: memory minus carry written back, optional post-inc
// - Pointer increment never touches flags; post-inc forms ignore extension
// - Bit set forces chosen bit in a short-addressed low or high word
// - Left shift of A or B in one cycle; bit three to carry
// - Radix forms report carry as a borrow relative to the radix
`timescale 1ns/1ps
`include "rsa_cfg.svh"
module rsa_core
  import rsa_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        issue_valid,
  input  wire logic [12:0] issue_code,
  input  wire logic        ext_load,
  input  wire logic [7:0]  address_extension_register,
  output logic             busy,
  output logic [15:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [3:0]       mem_wdata,
  input  wire logic [3:0]  mem_rdata,
  output logic [3:0]       reg_a,
  output logic [3:0]       reg_b,
  output logic [15:0]      ptr_x,
  output logic [15:0]      ptr_y,
  output logic             flag_c,
  output logic             flag_z,
  output logic             ext_flag
);
  rsa_mem_if au ();
  rsa_radix_sub u_sub (.au(au));

  rsa_state_type st_q, st_d;
  rsa_op_type    op_q;
  logic [12:0]   code_q;
  logic [3:0]    a_q, b_q, wdata_q;
  logic [15:0]   x_q, y_q, addr_q, addr_dec;
  logic          c_q, z_q, ext_q, rd_q, wr_q;
  logic          use_y, post_inc, ext_ok;
  logic [4:0]    radix_dec;
  logic [3:0]    memv;

  // Radix decode used by every radix form
  function automatic logic [4:0] radix_of(input logic [3:0] f);
    radix_of = (f == 4'h0) ? 5'h10 : {1'b0, f};
  endfunction : radix_of

  // Instruction class decode; every radix memory form lives in the 1Cxx block
  logic is_imm_sub, is_rreg, is_radix_mem, is_set, is_lshift;
  assign is_imm_sub   = (issue_code[12:4] == 9'h189) || (issue_code[12:4] == 9'h18B);
  assign is_rreg      = issue_code[12:4] == 9'h10C;
  assign is_radix_mem = issue_code[12:8] == 5'h1C;
  assign is_set       = issue_code[12:9] == 4'hB;
  assign is_lshift    = (issue_code == `RSA_OPC_LSHIFT_A) || (issue_code == `RSA_OPC_LSHIFT_B);
  assign use_y        = issue_code[5];
  assign post_inc     = is_imm_sub | issue_code[4];
  // Extended addressing only for non-incrementing memory forms
  assign ext_ok       = ext_q & is_radix_mem & ~post_inc;
  assign addr_dec =
    is_set ? {issue_code[8] ? `RSA_SHORT_PAGE_HI : `RSA_SHORT_PAGE_LO,
              issue_code[5:0]} :
    ext_ok ? {use_y ? `RSA_EXT_PAGE_Y : `RSA_EXT_PAGE_X,
              address_extension_register} :
    (use_y ? y_q : x_q);

  // Operand routing into the arithmetic unit
  assign memv       = mem_rdata;
  assign au.lhs     = (op_q == RSA_OP_RADIX_MSRC || op_q == RSA_OP_RADIX_REG) ? b_q : memv;
  assign au.rhs     = op_q == RSA_OP_RADIX_REG  ? a_q :
                      op_q == RSA_OP_RADIX_MSRC ? memv :
                      op_q == RSA_OP_RADIX_MDST ? b_q :
                      op_q == RSA_OP_RADIX_CARRY ? 4'h0 : code_q[3:0];
  assign au.cin     = c_q;
  assign au.radix   = radix_of(code_q[3:0]);
  assign au.adjust  = op_q != RSA_OP_IMM_SUB;

  // Decoded op class, latched into op_q at issue for the execute phase
  rsa_op_type op_sel;
  // Bits 7:6 pick source, destination or carry-only; pattern 2 is not a radix form
  assign op_sel = is_imm_sub ? RSA_OP_IMM_SUB :
                  is_rreg    ? RSA_OP_RADIX_REG :
                  is_set     ? RSA_OP_SET :
                  is_lshift  ? RSA_OP_LSHIFT :
                  !is_radix_mem ? RSA_OP_NONE :
                  issue_code[7:6] == 2'h3 ? RSA_OP_RADIX_MSRC :
                  issue_code[7:6] == 2'h1 ? RSA_OP_RADIX_MDST :
                  issue_code[7:6] == 2'h0 ? RSA_OP_RADIX_CARRY : RSA_OP_NONE;

  // Sequencer: issue, read phase, write phase
  always_comb begin
    st_d = st_q;
    case (st_q)
      RSA_ST_IDLE:  if (issue_valid && op_sel != RSA_OP_NONE && op_sel != RSA_OP_LSHIFT)
                      st_d = RSA_ST_READ;
      RSA_ST_READ:  st_d = RSA_ST_WRITE;
      RSA_ST_WRITE: st_d = RSA_ST_IDLE;
      default:      st_d = RSA_ST_IDLE;
    endcase
  end

  assign busy      = st_q != RSA_ST_IDLE;
  assign mem_addr  = addr_q;
  assign mem_rd    = rd_q;
  assign mem_wr    = wr_q;
  assign mem_wdata = wdata_q;
  assign reg_a     = a_q;
  assign reg_b     = b_q;
  assign ptr_x     = x_q;
  assign ptr_y     = y_q;
  assign flag_c    = c_q;
  assign flag_z    = z_q;
  assign ext_flag  = ext_q;

  logic to_mem, to_b;
  assign to_mem = op_q == RSA_OP_IMM_SUB || op_q == RSA_OP_RADIX_MDST ||
                  op_q == RSA_OP_RADIX_CARRY;
  assign to_b   = op_q == RSA_OP_RADIX_REG || op_q == RSA_OP_RADIX_MSRC;

  // State and datapath registers; subtract and bit-set results land in READ phase, shifts at issue
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q    <= RSA_ST_IDLE;
      op_q    <= RSA_OP_NONE;
      code_q  <= 13'h0000;
      a_q     <= `RSA_RST_NIB;
      b_q     <= `RSA_RST_NIB;
      wdata_q <= `RSA_RST_NIB;
      x_q     <= `RSA_RST_PTR;
      y_q     <= `RSA_RST_PTR;
      addr_q  <= `RSA_RST_PTR;
      c_q     <= 1'b0;
      z_q     <= 1'b0;
      ext_q   <= 1'b0;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
    end else begin
      st_q <= st_d;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      if (ext_load && st_q == RSA_ST_IDLE) begin
        ext_q <= 1'b1;
      end else if (st_q == RSA_ST_IDLE && issue_valid && op_sel != RSA_OP_NONE) begin
        ext_q  <= 1'b0;
        op_q   <= op_sel;
        code_q <= issue_code;
        addr_q <= addr_dec;
        rd_q   <= op_sel != RSA_OP_LSHIFT;
        if (op_sel == RSA_OP_LSHIFT) begin
          // Single cycle shift, zero enters bit 0
          if (issue_code[2]) begin
            b_q <= {b_q[2:0], 1'b0};
            c_q <= b_q[3];
            z_q <= b_q[2:0] == 3'h0;
          end else begin
            a_q <= {a_q[2:0], 1'b0};
            c_q <= a_q[3];
            z_q <= a_q[2:0] == 3'h0;
          end
        end
      end else if (st_q == RSA_ST_READ) begin
        // Memory data valid here; compute and stage write-back
        if (op_q == RSA_OP_SET) begin
          wdata_q <= mem_rdata | (4'h1 << code_q[7:6]);
          wr_q    <= 1'b1;
        end else begin
          c_q <= au.bout;
          z_q <= au.res == 4'h0;
          if (to_b) b_q <= au.res;
          if (to_mem) begin
            wdata_q <= au.res;
            wr_q    <= 1'b1;
          end
        end
      end else if (st_q == RSA_ST_WRITE) begin
        // Pointer bump after the result; flags left alone
        if (op_q != RSA_OP_SET && op_q != RSA_OP_RADIX_REG &&
            (op_q == RSA_OP_IMM_SUB || code_q[4])) begin
          if (code_q[5]) y_q <= y_q + 16'h0001;
          else           x_q <= x_q + 16'h0001;
        end
      end
    end
  end

  // Pointer increment keeps flags steady
  property p_inc_keeps_flags;
    @(posedge sys_clk) disable iff (srst)
      (st_q == RSA_ST_WRITE) |=> (c_q == $past(c_q) && z_q == $past(z_q));
  endproperty
  a_inc_keeps_flags: assert property (p_inc_keeps_flags) else $error("flags moved");

  // Two-cycle memory instructions write one cycle after reading
  property p_two_cycle;
    @(posedge sys_clk) disable iff (srst)
      (st_q == RSA_ST_READ && to_mem) |=> mem_wr ##1 !mem_wr;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("write timing");

  // Shift moves bit three into carry
  property p_lshift;
    @(posedge sys_clk) disable iff (srst)
      (st_q == RSA_ST_IDLE && issue_valid && issue_code == `RSA_OPC_LSHIFT_A && !ext_load)
      |=> (c_q == $past(a_q[3]) && a_q == {$past(a_q[2:0]), 1'b0});
  endproperty
  a_lshift: assert property (p_lshift) else $error("shift wrong");

  // Extension cleared after any instruction
  property p_ext_clear;
    @(posedge sys_clk) disable iff (srst)
      (st_q == RSA_ST_IDLE && issue_valid && op_sel != RSA_OP_NONE && !ext_load)
      |=> !ext_q;
  endproperty
  a_ext_clear: assert property (p_ext_clear) else $error("ext stuck");

  // Radix result stays below the radix
  property p_radix_range;
    @(posedge sys_clk) disable iff (srst)
      (st_q == RSA_ST_READ && au.adjust && au.lhs < au.radix && au.rhs < au.radix)
      |-> ({1'b0, au.res} < au.radix);
  endproperty
  a_radix_range: assert property (p_radix_range) else $error("radix overflow");

  // Set bit writes back with the chosen bit raised
  property p_set_bit;
    @(posedge sys_clk) disable iff (srst)
      (st_q == RSA_ST_READ && op_q == RSA_OP_SET)
      |=> mem_wr && mem_wdata[code_q[7:6]];
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("bit not set");

  // Zero radix field means sixteen
  property p_radix16;
    @(posedge sys_clk) disable iff (srst)
      (code_q[3:0] == 4'h0) |-> au.radix == 5'h10;
  endproperty
  a_radix16: assert property (p_radix16) else $error("radix decode");

  // Short address lands in top or bottom page
  property p_short_addr;
    @(posedge sys_clk) disable iff (srst)
      (op_q == RSA_OP_SET && busy) |-> (addr_q[15:6] == 10'h000 || addr_q[15:6] == 10'h3FF);
  endproperty
  a_short_addr: assert property (p_short_addr) else $error("short address");
endmodule : rsa_core

//--- dv/rsa_mem_model.sv
// Behavioural model of the 4-bit data memory behind the datapath
`timescale 1ns/1ps
module rsa_mem_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [3:0]  mem_wdata,
  output logic      [3:0]  mem_rdata
);
  logic [3:0] mem [0:65535];
  logic [3:0] last_q;

  // Clear storage once so the bench can preload single words
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 4'h0;
    last_q = 4'h0;
  end

  // Answer in the same cycle; outside reads show the inverse so stale data never matches
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;

  // Writes land at the clock edge that samples the strobe
  always @(posedge sys_clk) begin
    if (mem_wr) mem[mem_addr] <= mem_wdata;
    if (mem_rd) last_q <= mem[mem_addr];
  end
endmodule : rsa_mem_model

//--- dv/radix_subtract_shift_alu_tb.sv
// Self-checking bench for the radix subtract, bit set and left shift datapath
`timescale 1ns/1ps
module radix_subtract_shift_alu_tb;
  localparam int K_IMM = 0, K_REG = 1, K_BM = 2, K_MB = 3, K_CY = 4, K_SET = 5, K_SHL = 6;
  logic sys_clk = 1'b0, srst = 1'b1, issue_valid = 1'b0, ext_load = 1'b0;
  logic [12:0] issue_code = 13'h0000;
  logic [7:0]  ext_val = 8'h00;
  logic        busy, mem_rd, mem_wr, flag_c, flag_z, ext_flag;
  logic [15:0] mem_addr, ptr_x, ptr_y;
  logic [3:0]  mem_wdata, mem_rdata, reg_a, reg_b;
  logic [3:0]  ea = 4'h0, eb = 4'h0;
  logic        ec = 1'b0, ez = 1'b0;
  logic [15:0] px = 16'h0000, py = 16'h0000;
  int error_cnt = 0, cmp_count = 0, cyc_cnt = 0;

  always #10 sys_clk = ~sys_clk;

  rsa_core uut (.sys_clk(sys_clk), .srst(srst), .issue_valid(issue_valid),
    .issue_code(issue_code), .ext_load(ext_load), .address_extension_register(ext_val),
    .busy(busy), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .reg_a(reg_a), .reg_b(reg_b),
    .ptr_x(ptr_x), .ptr_y(ptr_y), .flag_c(flag_c), .flag_z(flag_z), .ext_flag(ext_flag));
  rsa_mem_model mem_u (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  task automatic summarize();
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // Hang guard: about two hundred cycles are expected, so this ceiling is generous
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk

  // Borrow folds back by the radix, so carry means a borrow in that radix
  function automatic logic [4:0] rsub(input logic [3:0] l, input logic [3:0] r,
                                      input logic c, input int n);
    int d;
    d = int'(l) - int'(r) - int'(c);
    if (d < 0) return {1'b1, 4'(d + n)};
    return {1'b0, 4'(d)};
  endfunction : rsub

  // Offer one instruction and count the cycles the datapath stays busy
  task automatic run(input logic [12:0] code, output int bc);
    bc = 0;
    issue_code = code;
    issue_valid = 1'b1;
    @(negedge sys_clk);
    issue_valid = 1'b0;
    repeat (6) begin
      if (busy === 1'b1) bc++;
      @(negedge sys_clk);
    end
  endtask : run

  task automatic ext(input logic [7:0] v);
    ext_val = v;
    ext_load = 1'b1;
    @(negedge sys_clk);
    ext_load = 1'b0;
    chk(16'(ext_flag), 16'h0001);
  endtask : ext

  // Execute one instruction, predict its effect and compare all visible state
  task automatic op(input logic [12:0] code, input logic [15:0] addr, input int kind,
                    input int n, input logic ix, input logic iy, input int cyc);
    logic [3:0] m;
    logic [4:0] r;
    int         bc;
    m = mem_u.mem[addr];
    case (kind)
      K_IMM: r = rsub(m, code[3:0], ec, 16);
      K_REG: r = rsub(eb, ea, ec, n);
      K_BM:  r = rsub(eb, m, ec, n);
      K_MB:  r = rsub(m, eb, ec, n);
      K_CY:  r = rsub(m, 4'h0, ec, n);
      K_SET: r = {ec, m | (4'h1 << code[7:6])};
      default: r = {code[2] ? eb[3] : ea[3], (code[2] ? eb : ea) << 1};
    endcase
    run(code, bc);
    if (cyc >= 0) chk(16'(bc), 16'(cyc));
    if (kind != K_SET) begin
      ec = r[4];
      ez = (r[3:0] == 4'h0);
    end
    if (kind == K_REG || kind == K_BM) eb = r[3:0];
    else if (kind == K_SHL && code[2]) eb = r[3:0];
    else if (kind == K_SHL) ea = r[3:0];
    else chk(16'(mem_u.mem[addr]), 16'(r[3:0]));
    px = px + 16'(ix);
    py = py + 16'(iy);
    chk(16'(reg_a), 16'(ea));
    chk(16'(reg_b), 16'(eb));
    chk(16'(flag_c), 16'(ec));
    chk(16'(flag_z), 16'(ez));
    chk(ptr_x, px);
    chk(ptr_y, py);
    chk(16'(ext_flag), 16'h0000);
  endtask : op

  task automatic t_sub_imm();
    op(13'h1893, px, K_IMM, 16, 1'b1, 1'b0, 2);
    op(13'h1897, px, K_IMM, 16, 1'b1, 1'b0, 2);
  endtask : t_sub_imm

  task automatic t_radix();
    op(13'h10CA, 16'h0000, K_REG, 10, 1'b0, 1'b0, 2);
    op(13'h10C0, 16'h0000, K_REG, 16, 1'b0, 1'b0, 2);
    ext(8'h10);
    op(13'h1CCA, 16'h0010, K_BM, 10, 1'b0, 1'b0, 2);
    ext(8'h20);
    op(13'h1CEA, 16'hFF20, K_BM, 10, 1'b0, 1'b0, 2);
    ext(8'h30);
    op(13'h1CDA, px, K_BM, 10, 1'b1, 1'b0, 2);
    op(13'h1C48, px, K_MB, 8, 1'b0, 1'b0, 2);
    op(13'h1C58, px, K_MB, 8, 1'b1, 1'b0, 2);
    op(13'h1C05, px, K_CY, 5, 1'b0, 1'b0, 2);
    op(13'h1C15, px, K_CY, 5, 1'b1, 1'b0, 2);
    op(13'h1C25, py, K_CY, 5, 1'b0, 1'b0, 2);
    op(13'h18B1, py, K_IMM, 16, 1'b0, 1'b1, 2);
    op(13'h1C60, py, K_MB, 16, 1'b0, 1'b0, 2);
  endtask : t_radix

  task automatic t_set_shift();
    for (int i = 0; i < 4; i++) begin
      op(13'h1600 | 13'(i << 6) | 13'h003F, 16'h003F, K_SET, 16, 1'b0, 1'b0, 2);
      op(13'h1700 | 13'(i << 6) | 13'h0005, 16'hFFC5, K_SET, 16, 1'b0, 1'b0, 2);
    end
    op(13'h10F0, 16'h0000, K_SHL, 16, 1'b0, 1'b0, 0);
    repeat (3) op(13'h10F4, 16'h0000, K_SHL, 16, 1'b0, 1'b0, 0);
  endtask : t_set_shift

  // Main sequence: reset, preload memory, then each scenario in turn
  initial begin
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    mem_u.mem[0] = 4'h5;
    mem_u.mem[1] = 4'h3;
    mem_u.mem[2] = 4'h1;
    mem_u.mem[3] = 4'h2;
    mem_u.mem[16'h0010] = 4'h3;
    mem_u.mem[16'hFF20] = 4'h7;
    @(negedge sys_clk);
    t_sub_imm();
    t_radix();
    t_set_shift();
    summarize();
  end
endmodule : radix_subtract_shift_alu_tb
